/* File: cp_regs_pkg.sv */
// constants, field layouts and carrier types for the processor register set
package cp_regs_pkg;

	localparam int ADDR_W = 18;
	localparam int OPER_W = 60;
	localparam int ABS_W = 21;
	localparam int EXT_W = 24;
	localparam int MASK_W = 6;
	localparam int NREG = 8;

	// register kinds on the write and read ports
	typedef enum logic [1:0] {
		K_ADDR = 2'b00,
		K_INDEX = 2'b01,
		K_OPER = 2'b10,
		K_PC = 2'b11
	} reg_kind_t;

	typedef struct packed {
		reg_kind_t kind;
		logic [2:0] idx;
		logic [OPER_W-1:0] data;
	} reg_wr_t;

	typedef struct packed {
		logic write;
		logic [2:0] idx;
		logic [ABS_W-1:0] addr;
		logic [OPER_W-1:0] data;
	} mem_req_t;

	typedef enum logic [1:0] {
		MS_IDLE = 2'b00,
		MS_REQ = 2'b01,
		MS_WAIT = 2'b10
	} mem_state_t;

	// exchange package word numbers, counted from zero
	localparam logic [2:0] XW_PC = 3'h0;
	localparam logic [2:0] XW_BASE = 3'h1;
	localparam logic [2:0] XW_LIMIT = 3'h2;
	localparam logic [2:0] XW_MODE = 3'h3;
	localparam logic [2:0] XW_EXT_BASE = 3'h4;
	localparam logic [2:0] XW_EXT_LIMIT = 3'h5;
	localparam logic [2:0] XW_MONITOR = 3'h6;

	// low bit of each field inside its exchange word
	localparam int PC_LSB = 0;
	localparam int BASE_LSB = 0;
	localparam int LIMIT_LSB = 0;
	localparam int EXT_BASE_LSB = 0;
	localparam int EXT_LIMIT_LSB = 0;
	localparam int MONITOR_LSB = 0;
	localparam int MASK_LO_LSB = 48;
	localparam int MASK_HI_LSB = 57;
	localparam int FLAG_LSB = 51;
	localparam int EXT_ZERO_W = 6;

	// exit mask bit numbers inside the 6-bit mask
	localparam int EM_RANGE = 0;
	localparam int EM_INFINITE = 1;
	localparam int EM_INDEFINITE = 2;
	localparam int EM_HW_LSB = 3;

	// control flag bit numbers inside the 6-bit flag register
	localparam int FL_HW_ERR = 0;
	localparam int FL_PURGE = 1;
	localparam int FL_CMU_INT = 2;
	localparam int FL_BLK_SEL = 3;
	localparam int FL_EXPANDED = 4;
	localparam int FL_EXT_EN = 5;

	// operand register 0 field used as block copy address
	localparam int BLK_X0_LSB = 30;

	localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
	localparam logic [OPER_W-1:0] OPER_RST = 60'h000000000000000;
	localparam logic [ABS_W-1:0] ABS_RST = 21'h000000;
	localparam logic [EXT_W-1:0] EXT_RST = 24'h000000;
	localparam logic [MASK_W-1:0] MASK_RST = 6'h00;

endpackage : cp_regs_pkg

/* File: cp_operating_support_registers.sv */
// operating and support registers of the central processor with store reference logic
//
// Operation
// - eight 18-bit address registers, zero general purpose
// - address 1-5 write reads store into operand
// - address 6-7 write stores matching operand
// - eight index registers, index zero reads zero
// - support registers change only at exchange, except the interrupted flag, which hardware sets mid-interval
// - program counter loads from first exchange word
// - absolute address is base plus relative
// - field limit checks address 1-7 relative addresses
// - exit mask forces error exit when set
// - mask bits: range, infinite, indefinite, hardware
// - control flags load from fourth word
// - purge flag enables extended lookahead purging
// - interrupted char move sets resume flag
// - block flag selects operand zero address bits
// - expanded flag selects extended addressing mode
// - extended store usable only when enabled
// - extended base loads, low six bits zero
// - extended limit checks extended relative addresses
// - monitor pointer loads from seventh word
// - eight 60-bit operand registers feed store
`timescale 1ns/100ps
module cp_operating_support_registers import cp_regs_pkg::*; (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic wr_valid,
	input wire reg_wr_t wr_req,
	output logic wr_busy_r,
	input wire logic rd_valid,
	input wire reg_kind_t rd_kind,
	input wire logic [2:0] rd_idx,
	output logic [OPER_W-1:0] rd_data_r,
	output logic rd_done_r,
	output mem_req_t mem_req_r,
	output logic mem_req_valid_r,
	input wire logic mem_ack,
	input wire logic mem_rd_valid,
	input wire logic [OPER_W-1:0] mem_rd_data,
	input wire logic xchg_ld_valid,
	input wire logic [2:0] xchg_word_sel,
	input wire logic [OPER_W-1:0] xchg_ld_data,
	input wire logic xchg_sv_valid,
	output logic [OPER_W-1:0] xchg_sv_data_r,
	output logic xchg_sv_done_r,
	input wire logic interval_end,
	output logic interval_active_r,
	output logic [ABS_W-1:0] fetch_addr_r,
	input wire logic cond_infinite,
	input wire logic cond_indefinite,
	input wire logic [2:0] cond_hw_err,
	output logic range_fault_r,
	output logic error_exit_r,
	input wire logic cmu_interrupted,
	output logic purge_ext_r,
	output logic [ABS_W-1:0] blk_copy_addr_r,
	output logic ext_expanded_r,
	output logic ext_enable_r,
	output logic [ADDR_W-1:0] monitor_pkg_pointer_r,
	input wire logic ext_valid,
	input wire logic [EXT_W-1:0] ext_rel_addr,
	output logic [EXT_W-1:0] ext_abs_addr_r,
	output logic ext_grant_r,
	output logic ext_fault_r
);

	////////////////////////////////////////////////////////////////////////
	// register storage

	logic [ADDR_W-1:0] address_regs [NREG];
	logic [ADDR_W-1:0] index_regs [NREG];
	logic [OPER_W-1:0] operand_regs [NREG];
	logic [ADDR_W-1:0] program_counter_r;
	logic [ABS_W-1:0] memory_base_r;
	logic [ABS_W-1:0] memory_field_limit_r;
	logic [MASK_W-1:0] exit_mask_r;
	logic [MASK_W-1:0] control_flags_r;
	logic [ABS_W-1:0] ext_mem_base_r;
	logic [EXT_W-1:0] ext_mem_limit_r;
	mem_state_t mem_state_r;

	////////////////////////////////////////////////////////////////////////
	// decode of the register write port

	logic addr_wr;
	logic addr_take;
	logic addr_ref;
	logic addr_oor;
	logic [ABS_W-1:0] rel_wide;
	logic xchg_take;
	logic mem_return;

	assign addr_wr = wr_valid && (wr_req.kind == K_ADDR);
	// address writes are ignored while a store reference is in flight
	assign addr_take = addr_wr && (mem_state_r == MS_IDLE);
	assign addr_ref = addr_take && (wr_req.idx != 3'h0);
	assign rel_wide = {3'h0, wr_req.data[ADDR_W-1:0]};
	assign addr_oor = rel_wide >= memory_field_limit_r;
	// reloads are refused inside an execution interval
	assign xchg_take = xchg_ld_valid && !interval_active_r;
	assign mem_return = (mem_state_r == MS_WAIT) && mem_rd_valid;

	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_regs
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					address_regs[gi] <= ADDR_RST;
				end else if (addr_take && wr_req.idx == gi) begin
					address_regs[gi] <= wr_req.data[ADDR_W-1:0];
				end
			end

			always_ff @(posedge ref_clk) begin
				if (sys_rst || gi == 0) begin
					index_regs[gi] <= ADDR_RST;
				end else if (wr_valid && wr_req.kind == K_INDEX && wr_req.idx == gi) begin
					index_regs[gi] <= wr_req.data[ADDR_W-1:0];
				end
			end

			// a returning store word wins over an instruction result
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					operand_regs[gi] <= OPER_RST;
				end else if (mem_return && mem_req_r.idx == gi) begin
					operand_regs[gi] <= mem_rd_data;
				end else if (wr_valid && wr_req.kind == K_OPER && wr_req.idx == gi) begin
					operand_regs[gi] <= wr_req.data;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// store reference sequencer, one reference outstanding

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mem_state_r <= MS_IDLE;
			mem_req_valid_r <= 1'b0;
			mem_req_r <= '0;
			wr_busy_r <= 1'b0;
		end else begin
			unique case (mem_state_r)
				MS_IDLE: begin
					if (addr_ref && !addr_oor) begin
						mem_state_r <= MS_REQ;
						mem_req_valid_r <= 1'b1;
						wr_busy_r <= 1'b1;
						mem_req_r.write <= wr_req.idx[2] && wr_req.idx[1];
						mem_req_r.idx <= wr_req.idx;
						mem_req_r.addr <= memory_base_r + rel_wide;
						mem_req_r.data <= operand_regs[wr_req.idx];
					end
				end
				MS_REQ: begin
					if (mem_ack) begin
						mem_req_valid_r <= 1'b0;
						if (mem_req_r.write) begin
							mem_state_r <= MS_IDLE;
							wr_busy_r <= 1'b0;
						end else begin
							mem_state_r <= MS_WAIT;
						end
					end
				end
				MS_WAIT: begin
					if (mem_rd_valid) begin
						mem_state_r <= MS_IDLE;
						wr_busy_r <= 1'b0;
					end
				end
				default: begin
					mem_state_r <= MS_IDLE;
					mem_req_valid_r <= 1'b0;
					wr_busy_r <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter: exchange load or instruction update

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			program_counter_r <= ADDR_RST;
		end else if (xchg_take && xchg_word_sel == XW_PC) begin
			program_counter_r <= xchg_ld_data[PC_LSB +: ADDR_W];
		end else if (wr_valid && wr_req.kind == K_PC) begin
			program_counter_r <= wr_req.data[ADDR_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// support registers, loaded word by word at exchange

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			memory_base_r <= ABS_RST;
			memory_field_limit_r <= ABS_RST;
			exit_mask_r <= MASK_RST;
			ext_mem_base_r <= ABS_RST;
			ext_mem_limit_r <= EXT_RST;
			monitor_pkg_pointer_r <= ADDR_RST;
		end else if (xchg_take) begin
			unique case (xchg_word_sel)
				XW_BASE: memory_base_r <= xchg_ld_data[BASE_LSB +: ABS_W];
				XW_LIMIT: memory_field_limit_r <= xchg_ld_data[LIMIT_LSB +: ABS_W];
				XW_MODE: begin
					exit_mask_r <= {xchg_ld_data[MASK_HI_LSB +: 3],
						xchg_ld_data[MASK_LO_LSB +: 3]};
				end
				XW_EXT_BASE: begin
					ext_mem_base_r <= {xchg_ld_data[EXT_BASE_LSB + EXT_ZERO_W +:
						ABS_W - EXT_ZERO_W], 6'h00};
				end
				XW_EXT_LIMIT: begin
					ext_mem_limit_r <= {xchg_ld_data[EXT_LIMIT_LSB + EXT_ZERO_W +:
						EXT_W - EXT_ZERO_W], 6'h00};
				end
				XW_MONITOR: monitor_pkg_pointer_r <= xchg_ld_data[MONITOR_LSB +: ADDR_W];
				default: begin
				end
			endcase
		end
	end

	// the interrupted flag is the one flag hardware sets mid-interval, so the
	// next save carries the resume indication; a reload in the same cycle loses
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			control_flags_r <= MASK_RST;
		end else if (xchg_take && xchg_word_sel == XW_MODE) begin
			control_flags_r <= xchg_ld_data[FLAG_LSB +: MASK_W];
			if (cmu_interrupted) begin
				control_flags_r[FL_CMU_INT] <= 1'b1;
			end
		end else if (cmu_interrupted) begin
			control_flags_r[FL_CMU_INT] <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			interval_active_r <= 1'b0;
		end else if (xchg_take && xchg_word_sel == XW_MONITOR) begin
			interval_active_r <= 1'b1;
		end else if (interval_end) begin
			interval_active_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// exchange save and register read port

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			xchg_sv_data_r <= OPER_RST;
			xchg_sv_done_r <= 1'b0;
		end else begin
			xchg_sv_done_r <= xchg_sv_valid;
			if (xchg_sv_valid) begin
				xchg_sv_data_r <= OPER_RST;
				unique case (xchg_word_sel)
					XW_PC: xchg_sv_data_r[PC_LSB +: ADDR_W] <= program_counter_r;
					XW_BASE: xchg_sv_data_r[BASE_LSB +: ABS_W] <= memory_base_r;
					XW_LIMIT: xchg_sv_data_r[LIMIT_LSB +: ABS_W] <= memory_field_limit_r;
					XW_MODE: begin
						xchg_sv_data_r[MASK_LO_LSB +: 3] <= exit_mask_r[2:0];
						xchg_sv_data_r[FLAG_LSB +: MASK_W] <= control_flags_r;
						xchg_sv_data_r[MASK_HI_LSB +: 3] <= exit_mask_r[5:3];
					end
					XW_EXT_BASE: xchg_sv_data_r[EXT_BASE_LSB +: ABS_W] <= ext_mem_base_r;
					XW_EXT_LIMIT: xchg_sv_data_r[EXT_LIMIT_LSB +: EXT_W] <= ext_mem_limit_r;
					XW_MONITOR: begin
						xchg_sv_data_r[MONITOR_LSB +: ADDR_W] <= monitor_pkg_pointer_r;
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_data_r <= OPER_RST;
			rd_done_r <= 1'b0;
		end else begin
			rd_done_r <= rd_valid;
			if (rd_valid) begin
				unique case (rd_kind)
					K_ADDR: rd_data_r <= {42'h0, address_regs[rd_idx]};
					K_INDEX: rd_data_r <= {42'h0, index_regs[rd_idx]};
					K_OPER: rd_data_r <= operand_regs[rd_idx];
					K_PC: rd_data_r <= {42'h0, program_counter_r};
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address forming, range check and exit decisions

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			fetch_addr_r <= ABS_RST;
			blk_copy_addr_r <= ABS_RST;
		end else begin
			fetch_addr_r <= memory_base_r + {3'h0, program_counter_r};
			blk_copy_addr_r <= memory_base_r + (control_flags_r[FL_BLK_SEL] ?
				operand_regs[0][BLK_X0_LSB +: ABS_W] :
				{3'h0, address_regs[0]});
		end
	end

	// a masked-off range fault still reports; the reference is dropped either way
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			range_fault_r <= 1'b0;
			error_exit_r <= 1'b0;
		end else begin
			range_fault_r <= addr_ref && addr_oor;
			error_exit_r <= (addr_ref && addr_oor && exit_mask_r[EM_RANGE]) ||
				(cond_infinite && exit_mask_r[EM_INFINITE]) ||
				(cond_indefinite && exit_mask_r[EM_INDEFINITE]) ||
				(|(cond_hw_err & exit_mask_r[EM_HW_LSB +: 3]));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			purge_ext_r <= 1'b0;
			ext_expanded_r <= 1'b0;
			ext_enable_r <= 1'b0;
		end else begin
			purge_ext_r <= control_flags_r[FL_PURGE];
			ext_expanded_r <= control_flags_r[FL_EXPANDED];
			ext_enable_r <= control_flags_r[FL_EXT_EN];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ext_abs_addr_r <= EXT_RST;
			ext_grant_r <= 1'b0;
			ext_fault_r <= 1'b0;
		end else begin
			ext_abs_addr_r <= {3'h0, ext_mem_base_r} + ext_rel_addr;
			ext_grant_r <= ext_valid && control_flags_r[FL_EXT_EN] &&
				(ext_rel_addr < ext_mem_limit_r);
			ext_fault_r <= ext_valid && (!control_flags_r[FL_EXT_EN] ||
				(ext_rel_addr >= ext_mem_limit_r));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	AST_RD_ISSUE: assert property (addr_ref && !addr_oor && !(&wr_req.idx[2:1]) |=>
		mem_req_valid_r && !mem_req_r.write &&
		mem_req_r.addr == $past(memory_base_r) + $past(rel_wide))
		else $error("read reference not issued");
	AST_WR_ISSUE: assert property (addr_ref && !addr_oor && (&wr_req.idx[2:1]) |=>
		mem_req_valid_r && mem_req_r.write && mem_req_r.data == $past(operand_regs[6 + 32'(wr_req.idx[0])]))
		else $error("write reference not issued");
	AST_B0_ZERO: assert property (rd_valid && rd_kind == K_INDEX && rd_idx == 3'h0 |=>
		rd_data_r == OPER_RST)
		else $error("index zero not zero");
	AST_STABLE: assert property (interval_active_r && $past(interval_active_r) |->
		$stable(memory_base_r) && $stable(memory_field_limit_r) && $stable(ext_mem_base_r) &&
		$stable(exit_mask_r) && $stable(ext_mem_limit_r) && $stable(monitor_pkg_pointer_r))
		else $error("support register changed in interval");
	AST_FETCH: assert property (##1 fetch_addr_r == $past(memory_base_r) +
		{3'h0, $past(program_counter_r)})
		else $error("fetch address wrong");
	AST_RANGE: assert property (addr_ref && addr_oor |=> range_fault_r && !mem_req_valid_r)
		else $error("out of range reference not stopped");
	AST_EXIT: assert property ((cond_infinite && exit_mask_r[EM_INFINITE]) ||
		(cond_indefinite && exit_mask_r[EM_INDEFINITE]) |=> error_exit_r)
		else $error("masked condition gave no exit");
	AST_QUIET: assert property (!addr_ref && !cond_infinite && !cond_indefinite &&
		cond_hw_err == 3'h0 |=> !error_exit_r)
		else $error("spurious error exit");
	AST_EXT_DENY: assert property (ext_valid && !control_flags_r[FL_EXT_EN] |=>
		!ext_grant_r && ext_fault_r)
		else $error("extended access while disabled");
	AST_EXT_LOW: assert property (ext_mem_base_r[5:0] == 6'h00 &&
		ext_mem_limit_r[5:0] == 6'h00)
		else $error("extended low bits not zero");
	AST_RETURN: assert property (mem_return |=>
		operand_regs[$past(mem_req_r.idx)] == $past(mem_rd_data) && !wr_busy_r)
		else $error("fetched word not delivered");

endmodule : cp_operating_support_registers

/* File: main_store_model.sv */
// behavioural main store answering the register set's store references
`timescale 1ns/100ps
module main_store_model import cp_regs_pkg::*; (
	input wire logic ref_clk,
	input wire mem_req_t mem_req_r,
	input wire logic mem_req_valid_r,
	input wire logic [1:0] lat,
	output logic mem_ack,
	output logic mem_rd_valid,
	output logic [OPER_W-1:0] mem_rd_data,
	output mem_req_t last_wr
);
	mem_req_t req;
	initial begin
		mem_ack = 1'b0;
		mem_rd_valid = 1'b0;
		mem_rd_data = 60'h5a5a5a5a5a5a5a5;
		last_wr = '0;
		forever begin
			@(negedge ref_clk);
			// no stale word is left on the data lines between returns
			mem_rd_data <= ~mem_rd_data;
			if (mem_req_valid_r === 1'b1) begin
				repeat (lat) @(negedge ref_clk);
				mem_ack <= 1'b1;
				req = mem_req_r;
				// record at acceptance so the bench sees it once busy drops
				if (req.write) begin
					last_wr <= req;
				end
				@(negedge ref_clk);
				mem_ack <= 1'b0;
				if (!req.write) begin
					repeat (lat) @(negedge ref_clk);
					mem_rd_valid <= 1'b1;
					mem_rd_data <= {req.addr, ~req.addr, 18'h0a5a5};
					@(negedge ref_clk);
					mem_rd_valid <= 1'b0;
					mem_rd_data <= {~req.addr, req.addr, 18'h15a5a};
				end
			end
		end
	end
endmodule : main_store_model

/* File: tb_top.sv */
// self-checking bench for the processor register set
`timescale 1ns/100ps
module tb_top import cp_regs_pkg::*;;
	logic ref_clk, sys_rst, wr_valid, wr_busy_r, rd_valid, rd_done_r, mem_req_valid_r, mem_ack;
	reg_wr_t wr_req;
	reg_kind_t rd_kind;
	logic [2:0] rd_idx, xchg_word_sel, cond_hw_err;
	logic [OPER_W-1:0] rd_data_r, mem_rd_data, xchg_ld_data, xchg_sv_data_r;
	mem_req_t mem_req_r, last_wr;
	logic mem_rd_valid, xchg_ld_valid, xchg_sv_valid, xchg_sv_done_r, interval_end;
	logic interval_active_r, cond_infinite, cond_indefinite, range_fault_r, error_exit_r;
	logic cmu_interrupted, purge_ext_r, ext_expanded_r, ext_enable_r, ext_valid;
	logic ext_grant_r, ext_fault_r;
	logic [ABS_W-1:0] fetch_addr_r, blk_copy_addr_r;
	logic [ADDR_W-1:0] monitor_pkg_pointer_r;
	logic [EXT_W-1:0] ext_rel_addr, ext_abs_addr_r;
	logic [1:0] lat;
	logic [4:0] seen;
	int err_total, check_count;
	int cyc = 0;

	cp_operating_support_registers u_dut (.ref_clk, .sys_rst, .wr_valid, .wr_req, .wr_busy_r,
		.rd_valid, .rd_kind, .rd_idx, .rd_data_r, .rd_done_r, .mem_req_r, .mem_req_valid_r,
		.mem_ack, .mem_rd_valid, .mem_rd_data, .xchg_ld_valid, .xchg_word_sel, .xchg_ld_data,
		.xchg_sv_valid, .xchg_sv_data_r, .xchg_sv_done_r, .interval_end, .interval_active_r,
		.fetch_addr_r, .cond_infinite, .cond_indefinite, .cond_hw_err, .range_fault_r,
		.error_exit_r, .cmu_interrupted, .purge_ext_r, .blk_copy_addr_r, .ext_expanded_r,
		.ext_enable_r, .monitor_pkg_pointer_r, .ext_valid, .ext_rel_addr, .ext_abs_addr_r,
		.ext_grant_r, .ext_fault_r);

	main_store_model u_mem (.ref_clk, .mem_req_r, .mem_req_valid_r, .lat, .mem_ack,
		.mem_rd_valid, .mem_rd_data, .last_wr);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// sticky record of pulses: request, range fault, error exit, grant, ext fault
	always @(posedge ref_clk) begin
		seen <= seen | {mem_req_valid_r, range_fault_r, error_exit_r, ext_grant_r, ext_fault_r};
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [OPER_W-1:0] got, input logic [OPER_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick

	// a leading edge keeps two calls from touching a strobe in one step
	task automatic pulse(ref logic s);
		tick(1);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse

	task automatic wr(input reg_kind_t k, input logic [2:0] i, input logic [OPER_W-1:0] d);
		tick(1);
		wr_valid = 1'b1;
		wr_req = '{k, i, d};
		tick(1);
		wr_valid = 1'b0;
	endtask : wr

	task automatic rd(input reg_kind_t k, input logic [2:0] i, input logic [OPER_W-1:0] e);
		tick(1);
		rd_valid = 1'b1;
		rd_kind = k;
		rd_idx = i;
		tick(1);
		rd_valid = 1'b0;
		chk(rd_done_r, 1'b1);
		chk(rd_data_r, e);
	endtask : rd

	task automatic xl(input logic [2:0] w, input logic [OPER_W-1:0] d);
		tick(1);
		xchg_ld_valid = 1'b1;
		xchg_word_sel = w;
		xchg_ld_data = d;
		tick(1);
		xchg_ld_valid = 1'b0;
	endtask : xl

	task automatic xs(input logic [2:0] w, input logic [OPER_W-1:0] e);
		tick(1);
		xchg_sv_valid = 1'b1;
		xchg_word_sel = w;
		tick(1);
		xchg_sv_valid = 1'b0;
		chk(xchg_sv_done_r, 1'b1);
		chk(xchg_sv_data_r, e);
	endtask : xs

	task automatic saw(input logic [4:0] e);
		tick(3);
		chk(seen, e);
		seen = '0;
	endtask : saw

	task automatic wait_idle;
		for (int n = 0; n < 40 && wr_busy_r !== 1'b0; n++) tick(1);
		chk(wr_busy_r, 1'b0);
	endtask : wait_idle

	function automatic logic [OPER_W-1:0] exp_rd(input logic [ABS_W-1:0] a);
		return {a, ~a, 18'h0a5a5};
	endfunction : exp_rd

	////////////////////////////////////////////////////////////////////////
	initial begin
		{sys_rst, wr_valid, rd_valid, xchg_ld_valid, xchg_sv_valid, interval_end} = 6'h20;
		{cond_infinite, cond_indefinite, cmu_interrupted, ext_valid, cond_hw_err} = 7'h00;
		wr_req = '0;
		rd_kind = K_ADDR;
		rd_idx = 3'h0;
		xchg_word_sel = 3'h0;
		xchg_ld_data = '0;
		ext_rel_addr = '0;
		lat = 2'h0;
		seen = '0;
		err_total = 0;
		check_count = 0;
		tick(5);
		sys_rst = 1'b0;
		rd(K_ADDR, 3'h5, '0);
		chk(interval_active_r, 1'b0);
		// word 6 goes last since it opens the interval
		xl(XW_PC, 60'h40);
		xl(XW_BASE, 60'h1000);
		xl(XW_LIMIT, 60'h800);
		xl(XW_MODE, 60'h393000000000000);
		xl(XW_EXT_BASE, 60'h107f);
		xl(XW_EXT_LIMIT, 60'h207f);
		xl(XW_MONITOR, 60'h12345);
		tick(2);
		chk(fetch_addr_r, 21'h001040);
		chk(monitor_pkg_pointer_r, 18'h12345);
		chk({purge_ext_r, ext_expanded_r, ext_enable_r}, 3'h7);
		chk(interval_active_r, 1'b1);
		xs(XW_MODE, 60'h393000000000000);
		xs(XW_EXT_BASE, 60'h1040);
		xs(XW_EXT_LIMIT, 60'h2040);
		xl(XW_BASE, 60'h2000);
		wr(K_PC, 3'h0, 60'h80);
		tick(2);
		chk(fetch_addr_r, 21'h001080);
		xs(XW_PC, 60'h80);
		xs(XW_BASE, 60'h1000);
		xs(XW_LIMIT, 60'h800);
		xs(XW_MONITOR, 60'h12345);
		seen = '0;
		ext_rel_addr = 24'h00203f;
		pulse(ext_valid);
		chk(ext_abs_addr_r, 24'h00307f);
		saw(5'h02);
		ext_rel_addr = 24'h002040;
		pulse(ext_valid);
		saw(5'h01);
		pulse(cond_infinite);
		saw(5'h04);
		pulse(cond_indefinite);
		saw(5'h00);
		for (int i = 0; i < 2; i++) begin
			tick(1);
			cond_hw_err = i ? 3'h6 : 3'h1;
			tick(1);
			cond_hw_err = 3'h0;
			saw(i ? 5'h00 : 5'h04);
		end
		pulse(cmu_interrupted);
		xs(XW_MODE, 60'h3b3000000000000);
		wr(K_INDEX, 3'h0, 60'h3ffff);
		rd(K_INDEX, 3'h0, '0);
		wr(K_INDEX, 3'h3, 60'h0abcd);
		rd(K_INDEX, 3'h3, 60'h0abcd);
		for (int i = 1; i < 8; i++) begin
			lat = 2'(i % 3);
			if (i > 5) begin
				wr(K_OPER, 3'(i), {4'(i), 56'h0123456789abcd});
			end
			wr(K_ADDR, 3'(i), 60'(18'h100 + i));
			chk(mem_req_valid_r, 1'b1);
			chk(mem_req_r.addr, 21'h001100 + 21'(i));
			chk(mem_req_r.write, i > 5);
			wait_idle();
			if (i > 5) begin
				chk(last_wr.data, {4'(i), 56'h0123456789abcd});
			end else begin
				rd(K_OPER, 3'(i), exp_rd(21'h001100 + 21'(i)));
			end
		end
		// the second write meets a reference in flight and must be dropped
		lat = 2'h2;
		tick(1);
		wr_valid = 1'b1;
		wr_req = '{K_ADDR, 3'h2, 60'h200};
		tick(1);
		wr_req = '{K_ADDR, 3'h3, 60'h300};
		tick(1);
		wr_valid = 1'b0;
		wait_idle();
		rd(K_ADDR, 3'h3, 60'h103);
		rd(K_OPER, 3'h2, exp_rd(21'h001200));
		seen = '0;
		wr(K_ADDR, 3'h1, 60'h800);
		saw(5'h0c);
		wr(K_ADDR, 3'h0, 60'h20);
		wr(K_OPER, 3'h0, 60'h00000c000000000);
		saw(5'h00);
		chk(blk_copy_addr_r, 21'h001020);
		pulse(interval_end);
		xl(XW_MODE, 60'h3d3000000000000);
		tick(2);
		chk(interval_active_r, 1'b0);
		chk(blk_copy_addr_r, 21'h001300);
		end_sim();
	end
endmodule : tb_top
